// ===== pkg/hkc_pkg.sv
package hkc_pkg;
   // Data path widths
   localparam int          RES_W        = 12;
   localparam int          RES_HI_W     = 4;
   localparam int          RES_LO_W     = 8;
   localparam int          CHAN_W       = 3;
   localparam int          RATE_W       = 3;
   localparam int          CNT_W        = 32;

   // Converter settle time after power-up, in ns
   localparam int          SETTLE_NS    = 1000;
   localparam int          CLK_NS       = 5;
   localparam int          SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   // Base tick of the periodic rate counter, in ns
   localparam int          TICK_NS      = 1000;
   localparam int          TICK_CYC     = (TICK_NS + CLK_NS - 1) / CLK_NS;

   // Power-off delay after a threshold shutdown event, in us
   localparam int          OFF_DLY_US   = 1000;
   localparam int          OFF_DLY_CYC  = (OFF_DLY_US * 1000) / CLK_NS;

   // Reset values of the held results and flags
   localparam logic [11:0] RES_RST      = 12'h000;
   localparam logic        FLAG_RST     = 1'b0;

   typedef enum logic [1:0] {HKC_SRC_MAN, HKC_SRC_SLOT0, HKC_SRC_SLOT1} hkc_src_t;
   typedef enum logic [1:0] {HKC_IDLE, HKC_WARM, HKC_CONV} hkc_state_t;
endpackage

// ===== rtl/hkc_slot.sv
`timescale 1ns/100ps
module hkc_slot #(
   parameter int unsigned OFF_DLY = hkc_pkg::OFF_DLY_CYC
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         limit_shutdown_enable,
   input  wire logic                         limit_polarity,
   input  wire logic [hkc_pkg::RES_HI_W-1:0] limit_high_part,
   input  wire logic [hkc_pkg::RES_LO_W-1:0] limit_low_part,
   input  wire logic                         result_valid,
   input  wire logic [hkc_pkg::RES_W-1:0]    result,
   input  wire logic                         flag_clear,
   output logic [hkc_pkg::RES_HI_W-1:0]      periodic_result_high,
   output logic [hkc_pkg::RES_LO_W-1:0]      periodic_result_low,
   output logic                              periodic_slot_flag,
   output logic                              power_off_request
);
   import hkc_pkg::*;

   logic [RES_W-1:0] limit;
   logic             trip;
   logic             dly_run_r;
   logic [CNT_W-1:0] dly_cnt_r;

   // Threshold assembled from its two parts
   assign limit = {limit_high_part, limit_low_part};

   // Polarity 1 trips above the limit, 0 trips below it
   assign trip = result_valid && (limit_polarity ? (result > limit) : (result < limit));

   // Latest result kept per slot, apart from the manual result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periodic_result_high <= RES_RST[11:8];
         periodic_result_low  <= RES_RST[7:0];
      end else if (result_valid) begin
         periodic_result_high <= result[11:8];
         periodic_result_low  <= result[7:0];
      end
   end

   // Sticky flag; a trip in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periodic_slot_flag <= FLAG_RST;
      end else if (trip) begin
         periodic_slot_flag <= 1'b1;
      end else if (flag_clear) begin
         periodic_slot_flag <= 1'b0;
      end
   end

   // Delay before power-off; clearing the flag cancels it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_run_r         <= 1'b0;
         dly_cnt_r         <= '0;
         power_off_request <= 1'b0;
      end else if (trip && limit_shutdown_enable && !dly_run_r && !power_off_request) begin
         dly_run_r <= 1'b1;
         dly_cnt_r <= '0;
      end else if (dly_run_r && flag_clear && !trip) begin
         dly_run_r <= 1'b0;
      end else if (dly_run_r) begin
         if (dly_cnt_r == CNT_W'(OFF_DLY - 1)) begin
            dly_run_r         <= 1'b0;
            power_off_request <= 1'b1;
         end else begin
            dly_cnt_r <= dly_cnt_r + 1'b1;
         end
      end
   end
endmodule

// ===== rtl/hkc_sequencer.sv
`timescale 1ns/100ps
// Behaviour
// - Converter powered on demand, or kept powered
// - Manual done interrupt passes only when unmasked
// - Start bit runs one conversion, sets done
// - Result is 12 bits, high 4, low 8
// - Periodic conversions of chosen channel at rate
// - Periodic result compared with 12-bit limit
// - Polarity selects above or below trip
// - Enabled shutdown powers off after delay
// - Limit trip sets periodic slot flag
// - Periodic runs only when enabled, own results
// - Second periodic slot behaves like the first
module hkc_sequencer #(
   parameter int unsigned POWER_OFF_DELAY = hkc_pkg::OFF_DLY_CYC
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Manual conversion control
   input  wire logic                         manual_mode_enable,
   input  wire logic [hkc_pkg::CHAN_W-1:0]   manual_channel_select,
   input  wire logic                         manual_start_bit,
   input  wire logic                         converter_keep_powered,
   output logic [hkc_pkg::RES_HI_W-1:0]      manual_result_high,
   output logic [hkc_pkg::RES_LO_W-1:0]      manual_result_low,
   // Periodic control, slot 0
   input  wire logic                         periodic_slot_enable0,
   input  wire logic [hkc_pkg::CHAN_W-1:0]   periodic_channel_select0,
   input  wire logic [hkc_pkg::RES_HI_W-1:0] limit_high_part0,
   input  wire logic [hkc_pkg::RES_LO_W-1:0] limit_low_part0,
   input  wire logic                         limit_polarity0,
   input  wire logic                         limit_shutdown_enable0,
   output logic [hkc_pkg::RES_HI_W-1:0]      periodic_result_high0,
   output logic [hkc_pkg::RES_LO_W-1:0]      periodic_result_low0,
   // Periodic control, second slot
   input  wire logic                         periodic_slot_enable1,
   input  wire logic [hkc_pkg::CHAN_W-1:0]   periodic_channel_select1,
   input  wire logic [hkc_pkg::RES_HI_W-1:0] limit_high_part1,
   input  wire logic [hkc_pkg::RES_LO_W-1:0] limit_low_part1,
   input  wire logic                         limit_polarity1,
   input  wire logic                         limit_shutdown_enable1,
   output logic [hkc_pkg::RES_HI_W-1:0]      periodic_result_high1,
   output logic [hkc_pkg::RES_LO_W-1:0]      periodic_result_low1,
   // Shared rate
   input  wire logic [hkc_pkg::RATE_W-1:0]   periodic_rate_count,
   // Interrupt status, clear and mask, bit 0 manual, 1 slot0, 2 slot1
   input  wire logic [2:0]                   irq_mask_third,
   input  wire logic [2:0]                   irq_clear_third,
   output logic [2:0]                        irq_status_third,
   output logic                              irq_out,
   // Shutdown toward the power state machine
   output logic                              power_off_request,
   // Converter core
   output logic                              core_power_on,
   output logic                              core_start,
   output logic [hkc_pkg::CHAN_W-1:0]        core_channel,
   input  wire logic                         core_done,
   input  wire logic [hkc_pkg::RES_W-1:0]    core_result
);
   import hkc_pkg::*;

   hkc_state_t       state_r;
   hkc_src_t         src_r;
   logic             man_pend_r;
   logic [1:0]       slot_pend_r;
   logic             powered_r;
   logic [CNT_W-1:0] warm_cnt_r;
   logic [CNT_W-1:0] tick_cnt_r;
   logic [RATE_W:0]  rate_cnt_r;
   logic             period_hit;
   logic             any_slot_en;
   logic             grab;
   hkc_src_t         grab_src;
   logic             manual_done_flag;
   logic             man_done;
   logic [1:0]       slot_valid;
   logic [1:0]       slot_off;
   logic [1:0]       slot_flag;

   assign any_slot_en = periodic_slot_enable0 | periodic_slot_enable1;

   // Rate divider: base tick, then (rate + 1) ticks per period
   // At-or-above test so a lowered rate acts at the next tick, not after a wrap
   assign period_hit = (tick_cnt_r == CNT_W'(TICK_CYC - 1)) &&
                       (rate_cnt_r >= {1'b0, periodic_rate_count});

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= '0;
         rate_cnt_r <= '0;
      end else if (!any_slot_en) begin
         tick_cnt_r <= '0;
         rate_cnt_r <= '0;
      end else if (tick_cnt_r == CNT_W'(TICK_CYC - 1)) begin
         tick_cnt_r <= '0;
         rate_cnt_r <= period_hit ? '0 : rate_cnt_r + 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end

   // Arbitration; manual first, then slot 0, then the second slot
   always_comb begin
      grab     = 1'b0;
      grab_src = HKC_SRC_MAN;
      if (state_r == HKC_IDLE) begin
         if (man_pend_r) begin
            grab = 1'b1;
         end else if (slot_pend_r[0]) begin
            grab     = 1'b1;
            grab_src = HKC_SRC_SLOT0;
         end else if (slot_pend_r[1]) begin
            grab     = 1'b1;
            grab_src = HKC_SRC_SLOT1;
         end
      end
   end

   // Manual request; the start bit is ignored outside manual mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         man_pend_r <= 1'b0;
      end else if (!manual_mode_enable) begin
         man_pend_r <= 1'b0;
      end else if (manual_start_bit) begin
         man_pend_r <= 1'b1;
      end else if (grab && grab_src == HKC_SRC_MAN) begin
         man_pend_r <= 1'b0;
      end
   end

   // Periodic requests; a disabled slot drops its pending request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_pend_r <= 2'b00;
      end else begin
         if (!periodic_slot_enable0) begin
            slot_pend_r[0] <= 1'b0;
         end else if (period_hit) begin
            slot_pend_r[0] <= 1'b1;
         end else if (grab && grab_src == HKC_SRC_SLOT0) begin
            slot_pend_r[0] <= 1'b0;
         end
         if (!periodic_slot_enable1) begin
            slot_pend_r[1] <= 1'b0;
         end else if (period_hit) begin
            slot_pend_r[1] <= 1'b1;
         end else if (grab && grab_src == HKC_SRC_SLOT1) begin
            slot_pend_r[1] <= 1'b0;
         end
      end
   end

   // Sequencer: settle the core if cold, then one conversion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= HKC_IDLE;
         src_r      <= HKC_SRC_MAN;
         warm_cnt_r <= '0;
         core_start <= 1'b0;
      end else begin
         core_start <= 1'b0;
         unique case (state_r)
            HKC_IDLE: begin
               if (grab) begin
                  src_r      <= grab_src;
                  warm_cnt_r <= '0;
                  if (powered_r) begin
                     state_r    <= HKC_CONV;
                     core_start <= 1'b1;
                  end else begin
                     state_r <= HKC_WARM;
                  end
               end
            end
            HKC_WARM: begin
               if (warm_cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
                  state_r    <= HKC_CONV;
                  core_start <= 1'b1;
               end else begin
                  warm_cnt_r <= warm_cnt_r + 1'b1;
               end
            end
            HKC_CONV: begin
               if (core_done && !core_start) begin
                  state_r <= HKC_IDLE;
               end
            end
         endcase
      end
   end

   // Channel latched at launch so it holds through the conversion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_channel <= '0;
      end else if (grab) begin
         unique case (grab_src)
            HKC_SRC_MAN:   core_channel <= manual_channel_select;
            HKC_SRC_SLOT0: core_channel <= periodic_channel_select0;
            HKC_SRC_SLOT1: core_channel <= periodic_channel_select1;
            default:       core_channel <= manual_channel_select;
         endcase
      end
   end

   // Power on demand; keep-powered skips the settle wait once one conversion has run while it is set
   assign core_power_on = converter_keep_powered || (state_r != HKC_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powered_r <= 1'b0;
      end else if (!converter_keep_powered) begin
         powered_r <= 1'b0;
      end else if (state_r == HKC_WARM && warm_cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
         powered_r <= 1'b1;
      end else if (state_r == HKC_CONV) begin
         powered_r <= 1'b1;
      end
   end

   // Completion routed to its requester
   assign man_done      = (state_r == HKC_CONV) && core_done && !core_start &&
                          (src_r == HKC_SRC_MAN);
   assign slot_valid[0] = (state_r == HKC_CONV) && core_done && !core_start &&
                          (src_r == HKC_SRC_SLOT0);
   assign slot_valid[1] = (state_r == HKC_CONV) && core_done && !core_start &&
                          (src_r == HKC_SRC_SLOT1);

   // Manual result split into high nibble and low byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_result_high <= RES_RST[11:8];
         manual_result_low  <= RES_RST[7:0];
      end else if (man_done) begin
         manual_result_high <= core_result[11:8];
         manual_result_low  <= core_result[7:0];
      end
   end

   // Done flag sticky; a completion in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_done_flag <= FLAG_RST;
      end else if (man_done) begin
         manual_done_flag <= 1'b1;
      end else if (irq_clear_third[0]) begin
         manual_done_flag <= 1'b0;
      end
   end

   // Identical periodic slots
   hkc_slot #(.OFF_DLY(POWER_OFF_DELAY)) u_slot0 (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .limit_shutdown_enable (limit_shutdown_enable0),
      .limit_polarity        (limit_polarity0),
      .limit_high_part       (limit_high_part0),
      .limit_low_part        (limit_low_part0),
      .result_valid          (slot_valid[0]),
      .result                (core_result),
      .flag_clear            (irq_clear_third[1]),
      .periodic_result_high  (periodic_result_high0),
      .periodic_result_low   (periodic_result_low0),
      .periodic_slot_flag    (slot_flag[0]),
      .power_off_request     (slot_off[0])
   );

   hkc_slot #(.OFF_DLY(POWER_OFF_DELAY)) u_slot1 (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .limit_shutdown_enable (limit_shutdown_enable1),
      .limit_polarity        (limit_polarity1),
      .limit_high_part       (limit_high_part1),
      .limit_low_part        (limit_low_part1),
      .result_valid          (slot_valid[1]),
      .result                (core_result),
      .flag_clear            (irq_clear_third[2]),
      .periodic_result_high  (periodic_result_high1),
      .periodic_result_low   (periodic_result_low1),
      .periodic_slot_flag    (slot_flag[1]),
      .power_off_request     (slot_off[1])
   );

   // Status and masked interrupt; a set mask bit blocks the event
   assign irq_status_third  = {slot_flag, manual_done_flag};
   assign irq_out           = |(irq_status_third & ~irq_mask_third);
   assign power_off_request = |slot_off;
endmodule

// ===== verification/hkc_checker.sv
`timescale 1ns/100ps
module hkc_checker
   import hkc_pkg::*;
#(
   parameter int unsigned POWER_OFF_DELAY = hkc_pkg::OFF_DLY_CYC
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         converter_keep_powered,
   input  wire logic [hkc_pkg::RES_HI_W-1:0] manual_result_high,
   input  wire logic [hkc_pkg::RES_LO_W-1:0] manual_result_low,
   input  wire logic                         limit_shutdown_enable0,
   input  wire logic [2:0]                   irq_mask_third,
   input  wire logic [2:0]                   irq_clear_third,
   input  wire logic [2:0]                   irq_status_third,
   input  wire logic                         irq_out,
   input  wire logic                         power_off_request,
   input  wire logic                         core_power_on,
   input  wire logic                         core_start,
   input  wire logic                         core_done,
   input  wire logic [hkc_pkg::RES_W-1:0]    core_result
);
   logic [15:0] pwr_cnt_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Cycles the core has been powered, saturating so it never wraps
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_cnt_r <= 16'h0000;
      end else if (!core_power_on) begin
         pwr_cnt_r <= 16'h0000;
      end else if (pwr_cnt_r != 16'hffff) begin
         pwr_cnt_r <= pwr_cnt_r + 16'h0001;
      end
   end

   // Shutdown must not follow a trip at once; the delay is well above 8
   sequence s_off_quiet;
      !power_off_request [*8];
   endsequence

   a_irq_out_mask: assert property (irq_out == |(irq_status_third & ~irq_mask_third))
      else $error("irq_out disagrees with unmasked status");
   a_done_flag_sticky: assert property (
      irq_status_third[0] && !irq_clear_third[0] |=> irq_status_third[0])
      else $error("manual done flag dropped without clear");
   a_slot_flag_sticky: assert property (
      irq_status_third[1] && !irq_clear_third[1] |=> irq_status_third[1])
      else $error("slot flag dropped without clear");
   a_start_one_cycle: assert property (core_start |=> !core_start)
      else $error("core start longer than one cycle");
   a_keep_power_on: assert property (converter_keep_powered |-> core_power_on)
      else $error("core unpowered while kept powered");
   a_start_when_powered: assert property (core_start |-> core_power_on)
      else $error("core started while unpowered");
   a_cold_settle_wait: assert property (
      core_start && !converter_keep_powered |-> pwr_cnt_r >= SETTLE_CYC - 2)
      else $error("cold start before settle time");
   a_done_result_load: assert property (
      $rose(irq_status_third[0]) |->
      $past(core_done) && {manual_result_high, manual_result_low} == $past(core_result))
      else $error("manual result not loaded with done flag");
   a_off_sticky: assert property (power_off_request |=> power_off_request)
      else $error("power off request dropped");
   a_off_delayed: assert property (
      $rose(irq_status_third[1]) && limit_shutdown_enable0 && !power_off_request
      |-> s_off_quiet)
      else $error("power off without delay");
endmodule

bind hkc_sequencer hkc_checker #(.POWER_OFF_DELAY(POWER_OFF_DELAY)) u_hkc_checker (
   .clk(clk), .rst_n(rst_n), .converter_keep_powered(converter_keep_powered),
   .manual_result_high(manual_result_high), .manual_result_low(manual_result_low),
   .limit_shutdown_enable0(limit_shutdown_enable0), .irq_mask_third(irq_mask_third),
   .irq_clear_third(irq_clear_third), .irq_status_third(irq_status_third), .irq_out(irq_out),
   .power_off_request(power_off_request), .core_power_on(core_power_on),
   .core_start(core_start), .core_done(core_done), .core_result(core_result));

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
   import hkc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, mode = 1'b0, start = 1'b0, keep = 1'b0, done = 1'b0;
   logic        en0 = 1'b0, pol0 = 1'b0, sd0 = 1'b0, en1 = 1'b0, pol1 = 1'b0, sd1 = 1'b0;
   logic [2:0]  mch = 3'h0, ch0 = 3'h0, ch1 = 3'h0, rate = 3'h0, mask = 3'h7, clr = 3'h0;
   logic [3:0]  lh0 = 4'h8, lh1 = 4'h1, mrh, r0h, r1h;
   logic [7:0]  ll0 = 8'h00, ll1 = 8'h00, mrl, r0l, r1l;
   logic [11:0] res = 12'h000;
   logic [2:0]  st, cch, last_ch = 3'h0;
   logic        irq, poff, pwr, cst;
   int          fail_count = 0, n_tests = 0, cycles = 0, n_starts = 0, wait_c = 0, lat, s;
   logic        tp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic [11:0] tv [4] = '{12'h801, 12'h800, 12'h7ff, 12'h800};
   logic        te [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   hkc_sequencer #(.POWER_OFF_DELAY(20)) u_hkc_sequencer (
      .clk(clk), .rst_n(rst_n), .manual_mode_enable(mode), .manual_channel_select(mch),
      .manual_start_bit(start), .converter_keep_powered(keep), .manual_result_high(mrh),
      .manual_result_low(mrl), .periodic_slot_enable0(en0), .periodic_channel_select0(ch0),
      .limit_high_part0(lh0), .limit_low_part0(ll0), .limit_polarity0(pol0),
      .limit_shutdown_enable0(sd0), .periodic_result_high0(r0h), .periodic_result_low0(r0l),
      .periodic_slot_enable1(en1), .periodic_channel_select1(ch1), .limit_high_part1(lh1),
      .limit_low_part1(ll1), .limit_polarity1(pol1), .limit_shutdown_enable1(sd1),
      .periodic_result_high1(r1h), .periodic_result_low1(r1l), .periodic_rate_count(rate),
      .irq_mask_third(mask), .irq_clear_third(clr), .irq_status_third(st), .irq_out(irq),
      .power_off_request(poff), .core_power_on(pwr), .core_start(cst), .core_channel(cch),
      .core_done(done), .core_result(res));

   always #2.5 clk = ~clk;

   // Core stand-in: each start is answered four cycles later
   always @(negedge clk) begin
      done <= (wait_c == 1);
      if (cst === 1'b1) begin
         n_starts <= n_starts + 1;
         last_ch <= cch;
         wait_c <= 4;
      end else if (wait_c > 0) begin
         wait_c <= wait_c - 1;
      end
   end

   // Hang guard, far above the roughly 11000 cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pulse_clr(input logic [2:0] m);
      clr = m;
      cyc(1);
      clr = 3'h0;
      cyc(1);
   endtask

   task automatic wait_bit(input int i, input int lim);
      int k;
      k = 0;
      while (st[i] !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
   endtask

   // One start pulse; lat counts cycles until the core is started
   task automatic manual(input logic [11:0] val);
      s = n_starts;
      res = val;
      start = 1'b1;
      lat = 0;
      @(negedge clk);
      start = 1'b0;
      while (n_starts == s && lat < 400) begin
         @(negedge clk);
         lat++;
      end
      wait_bit(0, 20);
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence; all inputs move on the falling edge
   initial begin
      cyc(20);
      rst_n = 1'b1;
      cyc(1);
      chk({mrh, mrl}, 12'h000);
      chk({8'h00, st, poff}, 12'h000);
      manual(12'h123);
      chk({11'h000, st[0]}, 12'h000);
      chk(12'(n_starts), 12'h000);
      mode = 1'b1;
      mch = 3'h5;
      manual(12'habc);
      chk({11'h000, lat >= 199}, 12'h001);
      chk({9'h000, last_ch}, 12'h005);
      chk({mrh, mrl}, 12'habc);
      chk({10'h000, st[0], irq}, 12'h002);
      mask = 3'h6;
      cyc(1);
      chk({11'h000, irq}, 12'h001);
      pulse_clr(3'h1);
      chk({10'h000, st[0], irq}, 12'h000);
      keep = 1'b1;
      cyc(1);
      chk({11'h000, pwr}, 12'h001);
      manual(12'h456);
      pulse_clr(3'h1);
      manual(12'h789);
      chk({11'h000, lat <= 4}, 12'h001);
      chk({mrh, mrl}, 12'h789);
      chk({11'h000, st[0]}, 12'h001);
      keep = 1'b0;
      mode = 1'b0;
      pulse_clr(3'h1);
      chk({11'h000, pwr}, 12'h000);
      // Limit 0x800 on channel 2, both polarities and the equal case
      mask = 3'h0;
      ch0 = 3'h2;
      en0 = 1'b1;
      for (int k = 0; k < 4; k++) begin
         pol0 = tp[k];
         res = tv[k];
         cyc(450);
         pulse_clr(3'h2);
         cyc(450);
         chk({11'h000, st[1]}, {11'h000, te[k]});
         chk({11'h000, irq}, {11'h000, te[k]});
      end
      chk({r0h, r0l}, 12'h800);
      chk({9'h000, last_ch}, 12'h002);
      en0 = 1'b0;
      ch1 = 3'h6;
      pol1 = 1'b1;
      en1 = 1'b1;
      res = 12'h200;
      cyc(450);
      pulse_clr(3'h6);
      cyc(450);
      chk({10'h000, st[2:1]}, 12'h002);
      chk({r1h, r1l}, 12'h200);
      chk({9'h000, last_ch}, 12'h006);
      en1 = 1'b0;
      pulse_clr(3'h4);
      cyc(450);
      s = n_starts;
      cyc(600);
      chk(12'(n_starts - s), 12'h000);
      // Rate 3 gives one conversion every 800 cycles
      rate = 3'h3;
      pol0 = 1'b1;
      res = 12'h100;
      en0 = 1'b1;
      cyc(1000);
      s = n_starts;
      cyc(2400);
      chk(12'(n_starts - s), 12'h003);
      chk({11'h000, st[1]}, 12'h000);
      // Trip with shutdown, first cancelled by a clear, then allowed
      rate = 3'h0;
      sd0 = 1'b1;
      res = 12'h900;
      wait_bit(1, 900);
      en0 = 1'b0;
      pulse_clr(3'h2);
      cyc(40);
      chk({11'h000, poff}, 12'h000);
      en0 = 1'b1;
      wait_bit(1, 900);
      cyc(15);
      chk({11'h000, poff}, 12'h000);
      cyc(10);
      chk({11'h000, poff}, 12'h001);
      // Mid-run reset drops the sticky request; second slot shuts down too
      en0 = 1'b0;
      rst_n = 1'b0;
      cyc(2);
      chk({8'h00, st, poff}, 12'h000);
      rst_n = 1'b1;
      sd1 = 1'b1;
      en1 = 1'b1;
      wait_bit(2, 900);
      cyc(15);
      chk({11'h000, poff}, 12'h000);
      cyc(10);
      chk({11'h000, poff}, 12'h001);
      summarize();
   end
endmodule
